//--- include/ppr_pkg.sv
// constants, types and state layout of the peripheral pin router
package ppr_pkg;

	// geometry
	localparam int NIN = 8;
	localparam int NPORT = 3;
	localparam int PORT_W = 8;
	localparam int NPIN = NPORT * PORT_W;
	localparam int NSRC = 64;
	localparam int IN_SEL_W = 5;
	localparam int OUT_SEL_W = 6;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// register offsets
	localparam logic [7:0] ADDR_IN_SEL = 8'h00;
	localparam logic [7:0] ADDR_OUT_SEL = 8'h10;
	localparam logic [7:0] ADDR_LOCK = 8'h30;
	localparam logic [7:0] ADDR_PORT = 8'h31;
	localparam logic [7:0] ADDR_DIR = 8'h34;
	localparam logic [7:0] ADDR_LAT = 8'h37;
	localparam logic [7:0] ADDR_ANA = 8'h3A;

	// lock register keys and field
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;
	localparam int LOCK_BIT = 0;

	// input selector fields
	localparam int IN_PORT_MSB = 4;
	localparam int IN_PORT_LSB = 3;
	localparam int IN_PIN_MSB = 2;
	localparam logic [1:0] PORT_RSVD = 2'h3;

	// output source codes
	localparam logic [5:0] SRC_LATCH = 6'h00;
	localparam logic [5:0] SRC_UART_TX = 6'h17;

	// input indices
	localparam int IN_UART_RX = 0;

	// reset values: uart rx, uart cts, int0, i2c scl, i2c sda, spi sck, spi sdi, ccp1
	localparam logic [NIN-1:0][IN_SEL_W-1:0] IN_SEL_RST = {
		5'h12, 5'h14, 5'h13, 5'h14, 5'h13, 5'h08, 5'h16, 5'h17};
	localparam logic [OUT_SEL_W-1:0] OUT_SEL_RST = 6'h00;
	localparam logic [PORT_W-1:0] DIR_RST = 8'hFF;
	localparam logic [PORT_W-1:0] ANA_RST = 8'hFF;
	localparam logic [PORT_W-1:0] LAT_RST = 8'h00;

	// unlock sequence states
	typedef enum logic [1:0] {
		PPR_KEY_IDLE = 2'b00,
		PPR_KEY_HALF = 2'b01,
		PPR_KEY_OPEN = 2'b10
	} ppr_key_e;

	// whole state of the router
	typedef struct packed {
		logic [NIN-1:0][IN_SEL_W-1:0] in_sel;
		logic [NPIN-1:0][OUT_SEL_W-1:0] out_sel;
		logic [NPORT-1:0][PORT_W-1:0] dir;
		logic [NPORT-1:0][PORT_W-1:0] lat;
		logic [NPORT-1:0][PORT_W-1:0] ana;
		logic locked;
		logic set_once;
		logic clr_once;
		ppr_key_e key;
		logic [DATA_W-1:0] rdata;
		logic [NPIN-1:0] sync1;
		logic [NPIN-1:0] sync2;
		logic [NIN-1:0] periph_in;
		logic [NPIN-1:0] pin_out;
		logic [NPIN-1:0] pin_oe_n;
	} ppr_state_s;

endpackage : ppr_pkg

//--- hdl/ppr_in_mux.sv
// one peripheral input selector: port and pin choice from the pin levels
`timescale 1ns/1ps
`default_nettype none
module ppr_in_mux (
	// selector
	input wire logic [ppr_pkg::IN_SEL_W-1:0] sel,
	// digital pin levels, port a in the low byte
	input wire logic [ppr_pkg::NPIN-1:0] pins,
	// routed level
	output logic data
);

	logic [1:0] port_sel;
	logic [2:0] pin_sel;

	// split the code into port and pin, reserved port reads low
	always_comb begin
		port_sel = sel[ppr_pkg::IN_PORT_MSB:ppr_pkg::IN_PORT_LSB];
		pin_sel = sel[ppr_pkg::IN_PIN_MSB:0];
		if (port_sel == ppr_pkg::PORT_RSVD) begin
			data = 1'b0;
		end else begin
			data = pins[{port_sel, pin_sel}];
		end
	end

endmodule : ppr_in_mux
`default_nettype wire

//--- hdl/ppr_out_mux.sv
// one pin output stage: source choice and driver enable
`timescale 1ns/1ps
`default_nettype none
module ppr_out_mux (
	// pin configuration
	input wire logic [ppr_pkg::OUT_SEL_W-1:0] sel,
	input wire logic lat,
	input wire logic dir_in,
	// peripheral sources
	input wire logic [ppr_pkg::NSRC-1:0] src_data,
	input wire logic [ppr_pkg::NSRC-1:0] src_dir_ovr,
	input wire logic [ppr_pkg::NSRC-1:0] src_drive,
	// pin drive
	output logic out,
	output logic oe_n
);

	// latch for code zero, else the chosen peripheral
	always_comb begin
		if (sel == ppr_pkg::SRC_LATCH) begin
			out = lat;
			oe_n = dir_in;
		end else begin
			out = src_data[sel];
			if (src_dir_ovr[sel]) begin
				oe_n = ~src_drive[sel];
			end else begin
				oe_n = dir_in;
			end
		end
	end

endmodule : ppr_out_mux
`default_nettype wire

//--- hdl/ppr_router.sv
// peripheral pin router: selectors, lock sequence, pin and peripheral routing
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - only digital signals pass the router; analog functions never pass through it.
// - input routing and output routing use separate, independent selector registers.
// - input selector code 5'b10111 routes port c pin 7 to uart receive.
// - output selector code 6'b010111 makes uart transmit drive that pin.
// - several peripheral inputs may pick one pin and all see its level.
// - port reads return real pin levels regardless of input routing.
// - digital input buffer works only with analog select cleared; software clears it.
// - every input selector uses the same pin set and encoding.
// - pin direction control normally owns the output driver.
// - uart and i2c sources override direction control while operating.
// - every output selector uses the same source set and encoding.
// - while locked, writes to all selectors are ignored.
// - lock bit changes only after writes 55h, AAh, then one bit update.
// - with one-way config, lock bit clears once and sets once per reset; the code sets it once and never lets it clear.
// - with one-way config, a set lock bit stays set until reset.
// - sleep never changes any routing selection.
// - power-on reset restores selector defaults; other resets keep them.
// - any device reset removes the one-way lock history.
// - input selector bits 4-3 pick port a, b, c; bits 7-5 read zero.
// - input selector bits 2-0 pick pin 0 to 7 in binary.
// - each input selector resets to its own default pin code.
// - output selector holds six bits, upper two read zero, power-on value zero.
module ppr_router (
	// clock and resets
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic por_n,
	// register port
	input wire logic [ppr_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [ppr_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [ppr_pkg::DATA_W-1:0] reg_rdata,
	// configuration
	input wire logic single_unlock_cfg,
	// device pins
	input wire logic [ppr_pkg::NPIN-1:0] pin_in,
	output logic [ppr_pkg::NPIN-1:0] pin_out,
	output logic [ppr_pkg::NPIN-1:0] pin_oe_n,
	// peripheral output sources, indexed by source code
	input wire logic [ppr_pkg::NSRC-1:0] src_data,
	input wire logic [ppr_pkg::NSRC-1:0] src_dir_ovr,
	input wire logic [ppr_pkg::NSRC-1:0] src_drive,
	// peripheral inputs and status
	output logic [ppr_pkg::NIN-1:0] periph_in,
	output logic routing_locked
);

	ppr_pkg::ppr_state_s q;
	ppr_pkg::ppr_state_s d;

	// combinational helpers
	logic [ppr_pkg::NPIN-1:0] dig_level;
	logic [ppr_pkg::NIN-1:0] in_route;
	logic [ppr_pkg::NPIN-1:0] out_route;
	logic [ppr_pkg::NPIN-1:0] oe_route;
	logic sel_wr_ok;
	logic lock_wr;
	logic lock_val_ok;
	logic lock_new;
	logic lock_set_ok;
	logic lock_clr_ok;

	// digital input buffers, gated by analog select
	always_comb begin
		dig_level = q.sync2 & ~q.ana;
	end

	// one input selector per peripheral input, all alike
	genvar gi;
	generate
		for (gi = 0; gi < ppr_pkg::NIN; gi++) begin : g_in
			ppr_in_mux u_in (
				.sel(q.in_sel[gi]),
				.pins(dig_level),
				.data(in_route[gi])
			);
		end
	endgenerate

	// one output stage per pin, all alike
	genvar gp;
	generate
		for (gp = 0; gp < ppr_pkg::NPIN; gp++) begin : g_out
			ppr_out_mux u_out (
				.sel(q.out_sel[gp]),
				.lat(q.lat[gp / ppr_pkg::PORT_W][gp % ppr_pkg::PORT_W]),
				.dir_in(q.dir[gp / ppr_pkg::PORT_W][gp % ppr_pkg::PORT_W]),
				.src_data(src_data),
				.src_dir_ovr(src_dir_ovr),
				.src_drive(src_drive),
				.out(out_route[gp]),
				.oe_n(oe_route[gp])
			);
		end
	endgenerate

	// lock sequence decisions
	always_comb begin
		sel_wr_ok = reg_wr && !q.locked;
		lock_wr = reg_wr && (reg_addr == ppr_pkg::ADDR_LOCK);
		lock_val_ok = (reg_wdata[ppr_pkg::DATA_W-1:1] == 7'h00);
		lock_new = reg_wdata[ppr_pkg::LOCK_BIT];
		// one-way: a single set, and a clear only before set or clear was used
		lock_set_ok = !(single_unlock_cfg && q.set_once);
		lock_clr_ok = !(single_unlock_cfg && (q.set_once || q.clr_once));
	end

	// next state
	always_comb begin
		d = q;
		// pin synchroniser, first stage read only by the second
		d.sync1 = pin_in;
		d.sync2 = q.sync1;
		// registered routing outputs
		d.periph_in = in_route;
		d.pin_out = out_route;
		d.pin_oe_n = oe_route;
		d.rdata = 8'h00;

		// register writes; sleep has no path into the selectors
		if (reg_wr) begin
			for (int i = 0; i < ppr_pkg::NIN; i++) begin
				if (sel_wr_ok && reg_addr == ppr_pkg::ADDR_IN_SEL + 8'(i)) begin
					d.in_sel[i] = reg_wdata[ppr_pkg::IN_SEL_W-1:0];
				end
			end
			for (int j = 0; j < ppr_pkg::NPIN; j++) begin
				if (sel_wr_ok && reg_addr == ppr_pkg::ADDR_OUT_SEL + 8'(j)) begin
					d.out_sel[j] = reg_wdata[ppr_pkg::OUT_SEL_W-1:0];
				end
			end
			for (int k = 0; k < ppr_pkg::NPORT; k++) begin
				if (reg_addr == ppr_pkg::ADDR_DIR + 8'(k)) begin
					d.dir[k] = reg_wdata;
				end
				if (reg_addr == ppr_pkg::ADDR_LAT + 8'(k)) begin
					d.lat[k] = reg_wdata;
				end
				if (reg_addr == ppr_pkg::ADDR_ANA + 8'(k)) begin
					d.ana[k] = reg_wdata;
				end
			end
		end

		// unlock key sequence
		if (reg_wr && !lock_wr) begin
			d.key = ppr_pkg::PPR_KEY_IDLE;
		end else if (lock_wr) begin
			case (q.key)
				ppr_pkg::PPR_KEY_IDLE: begin
					if (reg_wdata == ppr_pkg::KEY_FIRST) begin
						d.key = ppr_pkg::PPR_KEY_HALF;
					end
				end
				ppr_pkg::PPR_KEY_HALF: begin
					if (reg_wdata == ppr_pkg::KEY_SECOND) begin
						d.key = ppr_pkg::PPR_KEY_OPEN;
					end else if (reg_wdata == ppr_pkg::KEY_FIRST) begin
						d.key = ppr_pkg::PPR_KEY_HALF;
					end else begin
						d.key = ppr_pkg::PPR_KEY_IDLE;
					end
				end
				ppr_pkg::PPR_KEY_OPEN: begin
					d.key = ppr_pkg::PPR_KEY_IDLE;
					if (lock_val_ok) begin
						if (lock_new && lock_set_ok) begin
							d.locked = 1'b1;
							d.set_once = 1'b1;
						end else if (!lock_new && q.locked && lock_clr_ok) begin
							d.locked = 1'b0;
							d.clr_once = 1'b1;
						end
					end
				end
				default: begin
					d.key = ppr_pkg::PPR_KEY_IDLE;
				end
			endcase
		end

		// read data, valid only in the cycle after the strobe
		if (reg_rd) begin
			for (int i = 0; i < ppr_pkg::NIN; i++) begin
				if (reg_addr == ppr_pkg::ADDR_IN_SEL + 8'(i)) begin
					d.rdata = {3'h0, q.in_sel[i]};
				end
			end
			for (int j = 0; j < ppr_pkg::NPIN; j++) begin
				if (reg_addr == ppr_pkg::ADDR_OUT_SEL + 8'(j)) begin
					d.rdata = {2'h0, q.out_sel[j]};
				end
			end
			for (int k = 0; k < ppr_pkg::NPORT; k++) begin
				if (reg_addr == ppr_pkg::ADDR_PORT + 8'(k)) begin
					d.rdata = dig_level[k*ppr_pkg::PORT_W +: ppr_pkg::PORT_W];
				end
				if (reg_addr == ppr_pkg::ADDR_DIR + 8'(k)) begin
					d.rdata = q.dir[k];
				end
				if (reg_addr == ppr_pkg::ADDR_LAT + 8'(k)) begin
					d.rdata = q.lat[k];
				end
				if (reg_addr == ppr_pkg::ADDR_ANA + 8'(k)) begin
					d.rdata = q.ana[k];
				end
			end
			if (reg_addr == ppr_pkg::ADDR_LOCK) begin
				d.rdata = {7'h00, q.locked};
			end
		end

		// device reset: lock state and pin control, selectors kept
		if (!rst_n) begin
			d.locked = 1'b0;
			d.set_once = 1'b0;
			d.clr_once = 1'b0;
			d.key = ppr_pkg::PPR_KEY_IDLE;
			d.rdata = 8'h00;
			d.dir = {ppr_pkg::NPORT{ppr_pkg::DIR_RST}};
			d.lat = {ppr_pkg::NPORT{ppr_pkg::LAT_RST}};
			d.ana = {ppr_pkg::NPORT{ppr_pkg::ANA_RST}};
			d.sync1 = '0;
			d.sync2 = '0;
			d.periph_in = '0;
			d.pin_out = '0;
			d.pin_oe_n = '1;
		end

		// power-on reset additionally restores selector defaults
		if (!por_n) begin
			d.locked = 1'b0;
			d.set_once = 1'b0;
			d.clr_once = 1'b0;
			d.key = ppr_pkg::PPR_KEY_IDLE;
			d.rdata = 8'h00;
			d.dir = {ppr_pkg::NPORT{ppr_pkg::DIR_RST}};
			d.lat = {ppr_pkg::NPORT{ppr_pkg::LAT_RST}};
			d.ana = {ppr_pkg::NPORT{ppr_pkg::ANA_RST}};
			d.sync1 = '0;
			d.sync2 = '0;
			d.periph_in = '0;
			d.pin_out = '0;
			d.pin_oe_n = '1;
			d.in_sel = ppr_pkg::IN_SEL_RST;
			d.out_sel = {ppr_pkg::NPIN{ppr_pkg::OUT_SEL_RST}};
		end
	end

	// state register, resets handled synchronously above
	always_ff @(posedge sys_clk) begin
		q <= d;
	end

	// outputs straight from flip-flops
	always_comb begin
		reg_rdata = q.rdata;
		pin_out = q.pin_out;
		pin_oe_n = q.pin_oe_n;
		periph_in = q.periph_in;
		routing_locked = q.locked;
	end

endmodule : ppr_router
`default_nettype wire

//--- verif/ppr_pad_model.sv
// pad model: outside levels against the router's pin drive
`timescale 1ns/1ps
`default_nettype none
module ppr_pad_model (
	// drive from the router
	input wire logic [23:0] pin_out,
	input wire logic [23:0] pin_oe_n,
	// outside level on released pads
	input wire logic [23:0] ext_lvl,
	// level seen at the pads
	output logic [23:0] pin_in
);
	// a driven pad shows the router level
	always_comb pin_in = (pin_out & ~pin_oe_n) | (ext_lvl & pin_oe_n);
endmodule : ppr_pad_model
`default_nettype wire

//--- verif/ppr_router_props.sv
// port checker of the peripheral pin router
`timescale 1ns/1ps
`default_nettype none
module ppr_router_props (
	// clock and resets
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic por_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// lock and pins
	input wire logic single_unlock_cfg,
	input wire logic [23:0] pin_oe_n,
	input wire logic routing_locked
);
	logic set_seen_q;
	logic clr_seen_q;
	logic lk_wr;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n || !por_n);
	// write to the lock register
	assign lk_wr = reg_wr && reg_addr == ppr_pkg::ADDR_LOCK;
	// lock history since reset
	always_ff @(posedge sys_clk) begin
		if (!rst_n || !por_n) begin
			set_seen_q <= 1'b0;
			clr_seen_q <= 1'b0;
		end else begin
			if ($rose(routing_locked)) set_seen_q <= 1'b1;
			if ($fell(routing_locked)) clr_seen_q <= 1'b1;
		end
	end
	AST_IN_SEL_TOP: assert property (reg_rd && reg_addr < 8'h08 |=> reg_rdata[7:5] == 3'h0)
		else $error("input selector top bits set");
	AST_OUT_SEL_TOP: assert property (reg_rd && reg_addr >= 8'h10 && reg_addr < 8'h28
		|=> reg_rdata[7:6] == 2'h0) else $error("output selector top bits set");
	AST_LOCK_KEYS: assert property (!$stable(routing_locked)
		|-> $past(lk_wr && reg_wdata[7:1] == 7'h00)) else $error("lock moved without write");
	AST_LOCK_SET: assert property (lk_wr && reg_wdata == 8'h55 ##2 lk_wr && reg_wdata == 8'hAA
		##2 lk_wr && reg_wdata == 8'h01 && !single_unlock_cfg |=> routing_locked)
		else $error("lock not set");
	AST_LOCK_CLR: assert property (lk_wr && reg_wdata == 8'h55 ##2 lk_wr && reg_wdata == 8'hAA
		##2 lk_wr && reg_wdata == 8'h00 && !single_unlock_cfg |=> !routing_locked)
		else $error("lock not cleared");
	AST_LOCK_READ: assert property (reg_rd && reg_addr == ppr_pkg::ADDR_LOCK
		|=> reg_rdata == {7'h00, routing_locked}) else $error("lock read wrong");
	AST_ONE_WAY_HOLD: assert property (single_unlock_cfg && set_seen_q |-> !$fell(routing_locked))
		else $error("one-way lock cleared");
	AST_ONE_WAY_CLR: assert property (single_unlock_cfg && clr_seen_q |-> !$fell(routing_locked))
		else $error("second clear taken");
	AST_RESET_FREE: assert property (@(posedge sys_clk) disable iff (1'b0)
		!rst_n |=> pin_oe_n == 24'hFFFFFF && !routing_locked) else $error("reset left state");
endmodule : ppr_router_props
bind ppr_router ppr_router_props chk_u (.sys_clk(sys_clk), .rst_n(rst_n), .por_n(por_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .single_unlock_cfg(single_unlock_cfg), .pin_oe_n(pin_oe_n),
	.routing_locked(routing_locked));
`default_nettype wire

//--- verif/testbench.sv
// self-checking bench of the peripheral pin router
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic por_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic cfg = 1'b0;
	logic [23:0] ext_lvl = 24'h000000;
	logic [23:0] pin_in;
	logic [23:0] pin_out;
	logic [23:0] pin_oe_n;
	logic [63:0] src_data = 64'h0;
	logic [63:0] src_ovr = 64'h0;
	logic [63:0] src_drv = 64'h0;
	logic [7:0] periph_in;
	logic locked;
	int miscompares = 0;
	int num_checks = 0;
	// clock
	always #5 sys_clk = ~sys_clk;
	// router and pads
	ppr_router dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .por_n(por_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.single_unlock_cfg(cfg), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.src_data(src_data), .src_dir_ovr(src_ovr), .src_drive(src_drv),
		.periph_in(periph_in), .routing_locked(locked));
	ppr_pad_model pad_u (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_lvl(ext_lvl),
		.pin_in(pin_in));
	// compare and count
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		chk("read data", exp, reg_rdata);
	endtask : rd
	// settle through synchronisers, sample mid-cycle
	task automatic settle;
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask : settle
	task automatic keys(input logic [7:0] v);
		wr(ppr_pkg::ADDR_LOCK, ppr_pkg::KEY_FIRST);
		wr(ppr_pkg::ADDR_LOCK, ppr_pkg::KEY_SECOND);
		wr(ppr_pkg::ADDR_LOCK, v);
	endtask : keys
	task automatic do_reset(input logic p, input logic r);
		@(posedge sys_clk);
		por_n <= p;
		rst_n <= r;
		repeat (8) @(posedge sys_clk);
		por_n <= 1'b1;
		rst_n <= 1'b1;
	endtask : do_reset
	task automatic t_defaults;
		rd(ppr_pkg::ADDR_IN_SEL, {3'h0, ppr_pkg::IN_SEL_RST[0]});
		rd(ppr_pkg::ADDR_OUT_SEL + 8'h16, 8'h00);
	endtask : t_defaults
	task automatic t_inputs;
		wr(ppr_pkg::ADDR_ANA + 8'h02, 8'h00);
		wr(ppr_pkg::ADDR_IN_SEL + 8'h01, 8'h17);
		wr(ppr_pkg::ADDR_IN_SEL + 8'h02, 8'h18);
		ext_lvl <= 24'h800000;
		settle();
		chk("periph c7", 8'h03, periph_in);
		rd(ppr_pkg::ADDR_PORT + 8'h02, 8'h80);
		ext_lvl <= 24'hFFFFFF;
		settle();
		chk("periph all", 8'hFB, periph_in);
	endtask : t_inputs
	task automatic t_outputs;
		wr(ppr_pkg::ADDR_OUT_SEL + 8'h16, 8'h17);
		src_data[23] <= 1'b1;
		src_ovr[23] <= 1'b1;
		src_drv[23] <= 1'b1;
		settle();
		chk("c6 uart", 8'h01, {6'h0, pin_oe_n[22], pin_out[22]});
		@(posedge sys_clk);
		src_ovr[23] <= 1'b0;
		settle();
		chk("c6 dir", 8'h03, {6'h0, pin_oe_n[22], pin_out[22]});
		// sda source on pin c4, the pin its input selector already uses
		wr(ppr_pkg::ADDR_OUT_SEL + 8'h14, 8'h21);
		src_data[33] <= 1'b0;
		src_ovr[33] <= 1'b1;
		src_drv[33] <= 1'b1;
		settle();
		settle();
		chk("sda loop", 8'h00, {7'h0, periph_in[4]});
		wr(ppr_pkg::ADDR_OUT_SEL + 8'h03, 8'hFF);
		rd(ppr_pkg::ADDR_OUT_SEL + 8'h03, 8'h3F);
	endtask : t_outputs
	task automatic t_lock;
		keys(8'h01);
		wr(ppr_pkg::ADDR_IN_SEL, 8'h00);
		rd(ppr_pkg::ADDR_IN_SEL, 8'h17);
		wr(ppr_pkg::ADDR_LOCK, ppr_pkg::KEY_FIRST);
		wr(ppr_pkg::ADDR_DIR, 8'hFF);
		wr(ppr_pkg::ADDR_LOCK, ppr_pkg::KEY_SECOND);
		wr(ppr_pkg::ADDR_LOCK, 8'h00);
		rd(ppr_pkg::ADDR_LOCK, 8'h01);
		keys(8'h00);
		rd(ppr_pkg::ADDR_LOCK, 8'h00);
	endtask : t_lock
	task automatic t_one_way;
		do_reset(1'b1, 1'b0);
		rd(ppr_pkg::ADDR_IN_SEL + 8'h02, 8'h18);
		cfg <= 1'b1;
		keys(8'h00);
		keys(8'h01);
		rd(ppr_pkg::ADDR_LOCK, 8'h01);
		keys(8'h00);
		rd(ppr_pkg::ADDR_LOCK, 8'h01);
		do_reset(1'b0, 1'b1);
		rd(ppr_pkg::ADDR_IN_SEL + 8'h02, {3'h0, ppr_pkg::IN_SEL_RST[2]});
		keys(8'h01);
		rd(ppr_pkg::ADDR_LOCK, 8'h01);
	endtask : t_one_way
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	// main sequence
	initial begin
		repeat (8) @(posedge sys_clk);
		por_n <= 1'b1;
		rst_n <= 1'b1;
		t_defaults();
		t_inputs();
		t_outputs();
		t_lock();
		t_one_way();
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
